/* File: rtl/amc_map.vh */
`ifndef AMC_MAP_VH
`define AMC_MAP_VH
// Mode-control word layout
`define AMC_MAP_BIT 15
`define AMC_SCAN_HI 14
`define AMC_SCAN_LO 11
`define AMC_PICK_HI 10
`define AMC_PICK_LO 7
`define AMC_RST_HI 6
`define AMC_RST_LO 5
`define AMC_PM_HI 4
`define AMC_PM_LO 3
`define AMC_TAG_BIT 2
`define AMC_SWC_BIT 1
// Reset values
`define AMC_SCAN_RST 4'h1
`define AMC_PICK_RST 4'h0
`define AMC_PM_RST 2'h0
`define AMC_TAG_RST 1'b0
`define AMC_SWC_RST 1'b0
`define AMC_MUX_RST 4'h0
// Idle pin levels, bit order: sclk, cs_n, din, convert start
`define AMC_PIN_IDLE 4'h2
// Scan codes
`define AMC_SCAN_HOLD 4'h0
`define AMC_SCAN_MANUAL 4'h1
`define AMC_SCAN_REPEAT 4'h2
`define AMC_SCAN_SWEEP 4'h3
// Reset field codes
`define AMC_RST_FIFO 2'h1
`define AMC_RST_ALL 2'h2
// Frame timing in serial clock edges
`define AMC_FRAME_BITS 5'd16
`define AMC_MUX_FALL 5'd13
`endif

/* File: rtl/amc_mode_decode.v */
// Overview of operation
// RULE_01: Bit 15 zero routes word here
// RULE_02: Bits 4:3 select power mode
// RULE_03: Tag enable gives channel-prefixed 16-bit word
// RULE_04: Internal clock always tags channel
// RULE_05: Software trigger starts conversion at CS rise
// RULE_06: Controller rewrites trigger per conversion
// RULE_07: Scan code zero keeps scan mode
// RULE_08: Hold code still takes bits 6:3,1; the code also takes bit 2 (tag enable) under the hold code
// RULE_09: Controller may hold data line low
// RULE_10: Manual mode takes channel each frame
// RULE_11: Manual result returned next frame
// RULE_12: Manual: external clock, one channel, no averaging
// RULE_13: Repeat fills FIFO with 4-16 results
// RULE_14: Repeat: internal clock, picked channel, averaging
// RULE_15: Sweep converts channels 0 to N
// RULE_16: Sweep internal clock, ascending, averaging
// RULE_17: Sweep mux advances on 13th falling edge
// RULE_18: Averaging only with internal clock
// RULE_19: Bit 0 ignored
// RULE_20: New word applies at CS rise
`timescale 1ns/10ps
`default_nettype none
`include "amc_map.vh"
module amc_mode_decode (
  input wire clk_i,
  input wire sys_rst_i,
  input wire sclk_i,
  input wire cs_n_i,
  input wire din_i,
  input wire convert_start_pin_i,
  output reg [3:0] scan_mode_o,
  output reg [3:0] channel_pick_o,
  output reg [1:0] power_mode_select_o,
  output reg channel_tag_enable_o,
  output reg internal_clock_o,
  output reg averaging_allowed_o,
  output reg tag_output_o,
  output reg conv_start_o,
  output reg fifo_clear_o,
  output reg regs_reset_o,
  output reg [3:0] mux_channel_o,
  output reg [3:0] manual_result_channel_o
);
  // Pins in order: serial clock, select, data, convert start
  localparam [3:0] PIN_IDLE = `AMC_PIN_IDLE;
  wire [3:0] pin_raw;
  wire [3:0] pin_s;
  wire sclk_s;
  wire cs_n_s;
  wire din_s;
  wire cnv_s;
  assign pin_raw = {convert_start_pin_i, din_i, cs_n_i, sclk_i};
  assign sclk_s = pin_s[0];
  assign cs_n_s = pin_s[1];
  assign din_s = pin_s[2];
  assign cnv_s = pin_s[3];
  // Synchronisers reset to each pin's idle level: no false edge
  genvar g;
  generate
    for (g = 0; g < 4; g = g + 1) begin : g_sync
      amc_sync #(
        .RST_VAL(PIN_IDLE[g])
      ) u_sync (
        .clk_i(clk_i),
        .sys_rst_i(sys_rst_i),
        .d_i(pin_raw[g]),
        .q_o(pin_s[g])
      );
    end
  endgenerate

  reg sclk_q;
  reg cs_n_q;
  reg cnv_q;
  reg [15:0] shift_q;
  reg [4:0] rise_cnt_q;
  reg [4:0] fall_cnt_q;
  reg swc_q;
  reg [3:0] manual_pend_q;
  wire sclk_rise = sclk_s & ~sclk_q;
  wire sclk_fall = ~sclk_s & sclk_q;
  wire cs_fall = ~cs_n_s & cs_n_q;
  wire cs_rise = cs_n_s & ~cs_n_q;
  wire cnv_rise = cnv_s & ~cnv_q;
  wire [3:0] new_scan = shift_q[`AMC_SCAN_HI:`AMC_SCAN_LO];
  wire [3:0] new_pick = shift_q[`AMC_PICK_HI:`AMC_PICK_LO];
  wire [1:0] new_rst = shift_q[`AMC_RST_HI:`AMC_RST_LO];
  wire frame_ok = (rise_cnt_q == `AMC_FRAME_BITS);
  wire word_here = frame_ok & ~shift_q[`AMC_MAP_BIT]; // RULE_01
  wire is_int_d = (new_scan == `AMC_SCAN_REPEAT) |
    (new_scan == `AMC_SCAN_SWEEP);
  wire take_word = cs_rise & word_here; // RULE_20
  wire scan_known = (new_scan == `AMC_SCAN_MANUAL) | is_int_d;
  wire int_mode = (scan_mode_o == `AMC_SCAN_REPEAT) |
    (scan_mode_o == `AMC_SCAN_SWEEP);
  wire mux_step = !cs_n_s & sclk_fall &
    (fall_cnt_q == `AMC_MUX_FALL - 5'd1); // RULE_17

  always @(posedge clk_i) begin
    if (sys_rst_i) begin
      sclk_q <= 1'b0;
      cs_n_q <= 1'b1;
      cnv_q <= 1'b0;
      shift_q <= 16'h0000;
      rise_cnt_q <= 5'h00;
      fall_cnt_q <= 5'h00;
    end else begin
      sclk_q <= sclk_s;
      cs_n_q <= cs_n_s;
      cnv_q <= cnv_s;
      if (cs_fall) begin
        rise_cnt_q <= 5'h00;
        fall_cnt_q <= 5'h00;
      end else if (!cs_n_s) begin
        if (sclk_rise && rise_cnt_q != `AMC_FRAME_BITS) begin
          shift_q <= {shift_q[14:0], din_s};
          rise_cnt_q <= rise_cnt_q + 5'h01;
        end
        if (sclk_fall && fall_cnt_q != 5'h1f) begin
          fall_cnt_q <= fall_cnt_q + 5'h01;
        end
      end
    end
  end

  // Mode-control register fields
  always @(posedge clk_i) begin
    if (sys_rst_i) begin
      scan_mode_o <= `AMC_SCAN_RST;
      channel_pick_o <= `AMC_PICK_RST;
      power_mode_select_o <= `AMC_PM_RST;
      channel_tag_enable_o <= `AMC_TAG_RST;
      swc_q <= `AMC_SWC_RST;
    end else if (take_word) begin // RULE_20
      // Bit 0 never looked at
      power_mode_select_o <=
        shift_q[`AMC_PM_HI:`AMC_PM_LO]; // RULE_02 RULE_08 RULE_19
      channel_tag_enable_o <= shift_q[`AMC_TAG_BIT]; // RULE_08
      swc_q <= shift_q[`AMC_SWC_BIT]; // RULE_08
      // Hold and unknown codes keep scan mode and channel
      if (scan_known) begin // RULE_07
        scan_mode_o <= new_scan;
        channel_pick_o <= new_pick; // RULE_10
      end
    end
  end

  // Mode-derived flags
  always @(posedge clk_i) begin
    if (sys_rst_i) begin
      internal_clock_o <= 1'b0;
      averaging_allowed_o <= 1'b0;
      tag_output_o <= 1'b0;
    end else begin
      internal_clock_o <= int_mode; // RULE_12 RULE_14 RULE_16
      averaging_allowed_o <= int_mode; // RULE_18
      tag_output_o <= channel_tag_enable_o |
        internal_clock_o; // RULE_03 RULE_04
    end
  end

  // Conversion start, internal clock modes only: pin edge while trigger bit clear, or trigger bit at select rise
  always @(posedge clk_i) begin
    if (sys_rst_i) begin
      conv_start_o <= 1'b0;
    end else begin
      conv_start_o <= 1'b0;
      if (internal_clock_o && !swc_q && cnv_rise) begin
        conv_start_o <= 1'b1;
      end
      if (take_word && shift_q[`AMC_SWC_BIT]) begin
        if (new_scan == `AMC_SCAN_HOLD && internal_clock_o) begin
          conv_start_o <= 1'b1; // RULE_05 RULE_06 RULE_07
        end else if (is_int_d) begin
          conv_start_o <= 1'b1; // RULE_05
        end
      end
    end
  end

  // Reset field pulses; the FIFO is cleared by both codes
  always @(posedge clk_i) begin
    if (sys_rst_i) begin
      fifo_clear_o <= 1'b0;
      regs_reset_o <= 1'b0;
    end else begin
      fifo_clear_o <= take_word &
        ((new_rst == `AMC_RST_FIFO) | (new_rst == `AMC_RST_ALL)); // RULE_08
      regs_reset_o <= take_word & (new_rst == `AMC_RST_ALL); // RULE_08
    end
  end

  // Input mux: reloaded by a scan word, stepped once per frame in sweep mode
  always @(posedge clk_i) begin
    if (sys_rst_i) begin
      mux_channel_o <= `AMC_MUX_RST;
    end else if (take_word && scan_known) begin
      if (new_scan == `AMC_SCAN_SWEEP) begin
        mux_channel_o <= 4'h0; // RULE_15
      end else begin
        mux_channel_o <= new_pick;
      end
    end else if (mux_step) begin
      if (scan_mode_o == `AMC_SCAN_SWEEP) begin
        if (mux_channel_o >= channel_pick_o) begin // RULE_15
          mux_channel_o <= 4'h0;
        end else begin
          mux_channel_o <= mux_channel_o + 4'h1; // RULE_17 RULE_16
        end
      end else if (scan_mode_o == `AMC_SCAN_REPEAT) begin
        mux_channel_o <= channel_pick_o; // RULE_13 RULE_14
      end
    end
  end

  // Manual mode: channel named now is reported next frame
  always @(posedge clk_i) begin
    if (sys_rst_i) begin
      manual_pend_q <= 4'h0;
      manual_result_channel_o <= 4'h0;
    end else if (take_word && new_scan == `AMC_SCAN_MANUAL) begin
      manual_result_channel_o <= manual_pend_q; // RULE_11
      manual_pend_q <= new_pick; // RULE_10 RULE_12
    end
  end
endmodule // amc_mode_decode
`default_nettype wire

/* File: rtl/amc_sync.v */
`timescale 1ns/10ps
`default_nettype none
module amc_sync #(
  parameter [0:0] RST_VAL = 1'b0
) (
  input wire clk_i,
  input wire sys_rst_i,
  input wire d_i,
  output reg q_o
);
  reg meta_q;
  always @(posedge clk_i) begin
    if (sys_rst_i) begin
      meta_q <= RST_VAL;
      q_o <= RST_VAL;
    end else begin
      meta_q <= d_i;
      q_o <= meta_q;
    end
  end
endmodule // amc_sync
`default_nettype wire

/* File: test/adc_mode_control_decode_test.sv */
`timescale 1ns/10ps
`default_nettype none
module adc_mode_control_decode_test;
  logic clk_i = 0, rst = 1, cnv = 0;
  wire sclk, cs_n, din, tag, ic, av, tout, conv, fclr, rrst;
  wire [3:0] scan, pick, mux, res;
  wire [1:0] pm;
  int miscompares = 0, n_tests = 0, n_conv = 0, n_fclr = 0, n_rrst = 0;
  logic [3:0] m0;
  always #25 clk_i = ~clk_i;
  always @(posedge clk_i) begin
    if (conv === 1'b1) n_conv <= n_conv + 1;
    if (fclr === 1'b1) n_fclr <= n_fclr + 1;
    if (rrst === 1'b1) n_rrst <= n_rrst + 1;
  end
  amc_master i_m (.clk_i(clk_i), .sclk_o(sclk), .cs_n_o(cs_n), .din_o(din));
  amc_mode_decode i_dut (.clk_i(clk_i), .sys_rst_i(rst), .sclk_i(sclk),
    .cs_n_i(cs_n), .din_i(din), .convert_start_pin_i(cnv),
    .scan_mode_o(scan), .channel_pick_o(pick), .power_mode_select_o(pm),
    .channel_tag_enable_o(tag), .internal_clock_o(ic),
    .averaging_allowed_o(av), .tag_output_o(tout), .conv_start_o(conv),
    .fifo_clear_o(fclr), .regs_reset_o(rrst), .mux_channel_o(mux),
    .manual_result_channel_o(res));
  task automatic chk(input string s, input logic [15:0] seen, exp);
    n_tests++;
    if (seen !== exp) begin
      miscompares++;
      $display("CHECK FAILED %s exp %h seen %h", s, exp, seen);
    end
  endtask
  // Bit 0 always set; it must be ignored
  task automatic wr(input logic [3:0] sc, pk, input logic [1:0] p,
    input logic t, sw);
    i_m.send({1'b0, sc, pk, 2'h0, p, t, sw, 1'b1});
  endtask
  task automatic st(input logic [3:0] sc, pk, input logic [1:0] p,
    input logic t);
    chk("scan", scan, sc);
    chk("pick", pick, pk);
    chk("pm", pm, p);
    chk("tag", tag, t);
  endtask
  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", n_tests, miscompares);
    if (miscompares == 0 && n_tests > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  initial begin
    #1ms;
    miscompares++;
    tally_and_finish;
  end
  initial begin
    repeat (10) @(negedge clk_i);
    rst = 0;
    repeat (4) @(negedge clk_i);
    st(1, 0, 0, 0);
    wr(3, 5, 2, 1, 0);
    st(3, 5, 2, 1);
    wr(0, 9, 1, 0, 1);
    st(3, 5, 1, 0);
    chk("tag_out", tout, 1);
    chk("conv", n_conv, 1);
    i_m.send(16'hffff);
    st(3, 5, 1, 0);
    wr(1, 4, 0, 0, 1);
    chk("int_clk", ic, 0);
    chk("conv", n_conv, 1);
    wr(1, 7, 0, 0, 0);
    chk("res_ch", res, 4);
    wr(2, 6, 0, 0, 0);
    chk("avg", av, 1);
    cnv = 1;
    repeat (6) @(negedge clk_i);
    cnv = 0;
    repeat (6) @(negedge clk_i);
    chk("conv", n_conv, 2);
    wr(0, 0, 0, 0, 1);
    st(2, 6, 0, 0);
    chk("conv", n_conv, 3);
    cnv = 1;
    repeat (6) @(negedge clk_i);
    cnv = 0;
    repeat (6) @(negedge clk_i);
    chk("conv", n_conv, 3);
    wr(3, 2, 0, 0, 0);
    for (int k = 0; k < 3; k++) begin
      m0 = mux;
      i_m.send(16'h0000);
      chk("mux", mux, (m0 >= 4'h2) ? 4'h0 : m0 + 4'h1);
    end
    i_m.send(16'h0020);
    chk("fifo_clr", n_fclr, 1);
    chk("regs_rst", n_rrst, 0);
    i_m.send(16'h0040);
    chk("fifo_clr", n_fclr, 2);
    chk("regs_rst", n_rrst, 1);
    rst = 1;
    repeat (10) @(negedge clk_i);
    rst = 0;
    repeat (4) @(negedge clk_i);
    st(1, 0, 0, 0);
    chk("int_clk", ic, 0);
    chk("mux", mux, 0);
    tally_and_finish;
  end
endmodule // adc_mode_control_decode_test
`default_nettype wire

/* File: test/amc_master.sv */
`timescale 1ns/10ps
`default_nettype none
module amc_master (
  input wire logic clk_i,
  output logic sclk_o,
  output logic cs_n_o,
  output logic din_o
);
  initial {sclk_o, cs_n_o, din_o} = 3'b010;
  // One MSB-first frame; clock idles low, data flips once released
  task automatic send(input logic [15:0] w);
    @(negedge clk_i) cs_n_o = 0;
    for (int i = 15; i >= 0; i--) begin
      din_o = w[i];
      repeat (4) @(negedge clk_i);
      sclk_o = 1;
      repeat (4) @(negedge clk_i);
      sclk_o = 0;
    end
    cs_n_o = 1;
    din_o = ~din_o;
    repeat (8) @(negedge clk_i);
  endtask
endmodule // amc_master
`default_nettype wire

/* File: test/amc_mode_decode_checker.sv */
`timescale 1ns/10ps
`default_nettype none
module amc_mode_decode_checker (
  input wire logic clk_i,
  input wire logic sys_rst_i,
  input wire logic sclk_i,
  input wire logic cs_n_i,
  input wire logic [3:0] scan_mode_o,
  input wire logic [3:0] channel_pick_o,
  input wire logic channel_tag_enable_o,
  input wire logic internal_clock_o,
  input wire logic averaging_allowed_o,
  input wire logic tag_output_o,
  input wire logic conv_start_o,
  input wire logic fifo_clear_o,
  input wire logic regs_reset_o,
  input wire logic [3:0] mux_channel_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (sys_rst_i);
  a_tag_follows: assert property (
    tag_output_o == $past(channel_tag_enable_o | internal_clock_o))
    else $error("tag output wrong");
  a_int_clock: assert property (
    internal_clock_o == $past(scan_mode_o inside {4'h2, 4'h3}))
    else $error("clock mode wrong");
  a_avg_int_only: assert property (
    averaging_allowed_o == $past(scan_mode_o inside {4'h2, 4'h3}))
    else $error("averaging wrong");
  a_regs_at_cs: assert property (
    !$stable({scan_mode_o, channel_pick_o, channel_tag_enable_o})
    |-> $past(cs_n_i, 2)) else $error("update inside frame");
  a_conv_pulse: assert property (
    conv_start_o |=> !conv_start_o) else $error("start not a pulse");
  a_pick_scan: assert property (
    $changed(channel_pick_o) |-> scan_mode_o inside {4'h1, 4'h2, 4'h3})
    else $error("channel changed under hold");
  a_scan_kept: assert property (
    scan_mode_o != 4'h0) else $error("hold code stored");
  a_mux_edge: assert property (
    $changed(mux_channel_o) |-> !$past(sclk_i, 2)) else $error("mux timing");
  a_rst_pair: assert property (
    regs_reset_o |-> fifo_clear_o) else $error("full reset without clear");
endmodule // amc_mode_decode_checker
bind amc_mode_decode amc_mode_decode_checker i_chk (
  .clk_i(clk_i),
  .sys_rst_i(sys_rst_i),
  .sclk_i(sclk_i),
  .cs_n_i(cs_n_i),
  .scan_mode_o(scan_mode_o),
  .channel_pick_o(channel_pick_o),
  .channel_tag_enable_o(channel_tag_enable_o),
  .internal_clock_o(internal_clock_o),
  .averaging_allowed_o(averaging_allowed_o),
  .tag_output_o(tag_output_o),
  .conv_start_o(conv_start_o),
  .fifo_clear_o(fifo_clear_o),
  .regs_reset_o(regs_reset_o),
  .mux_channel_o(mux_channel_o)
);
`default_nettype wire
